/* src/cmpeq_pkg.sv */
`default_nettype none

package cmpeq_pkg;

	// ----------------------------------------
	// Opcode fields
	// ----------------------------------------
	localparam logic [7:0] OPC_LONG = 8'h5F;
	localparam logic [7:0] OPC_SHORT = 8'h5B;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 8;
	localparam int IND_BIT = 7;
	localparam int FIELD_HI = 6;

	// ----------------------------------------
	// Lengths, counts and reset values
	// ----------------------------------------
	localparam logic [1:0] WORDS_SHORT = 2'h1;
	localparam logic [1:0] WORDS_LONG = 2'h2;
	localparam logic [1:0] EXTRA_LONG = 2'h1;
	localparam logic [1:0] EXTRA_CONFLICT = 2'h1;
	localparam int REPEAT_W = 8;
	localparam logic FLAG_RESET = 1'h0;
	localparam logic [15:0] CONST_RESET = 16'h0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_COMPARE = 2'b10
	} state_e;

	typedef struct packed {
		logic hit;
		logic long_form;
		logic indirect;
		logic [6:0] field;
	} decode_s;

endpackage

`default_nettype wire

/* src/opcode_decode.sv */
`default_nettype none

module opcode_decode (
	// Instruction word
	input wire logic [15:0] instr_word,
	// Decoded form
	output var cmpeq_pkg::decode_s dec
);

	wire logic [7:0] opc_hi = instr_word[cmpeq_pkg::OPC_HI:cmpeq_pkg::OPC_LO];
	wire logic is_long = (opc_hi == cmpeq_pkg::OPC_LONG);
	wire logic is_short = (opc_hi == cmpeq_pkg::OPC_SHORT);

	assign dec.hit = is_long | is_short;
	assign dec.long_form = is_long;
	assign dec.indirect = instr_word[cmpeq_pkg::IND_BIT];
	assign dec.field = instr_word[cmpeq_pkg::FIELD_HI:0];

endmodule

`default_nettype wire

/* src/compare_equal_instr.sv */
// Contract
// - Opcode high byte 01011111 is the long form; bit 7 picks indirect; constant follows.
// - Opcode high byte 01011011 is the short form; bit 7 picks indirect addressing.
// - Short form advances program counter by one, compares operand with bit_manip_reg.
// - Long form advances program counter by two, compares operand with the constant.
// - Flag set when equal, cleared otherwise; operands are never modified.
// - Instruction length is one word short, two words long.
// - Same single_access_ram block for operand and code adds one cycle.
`default_nettype none

module compare_equal_instr (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Instruction issue
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] long_word,
	output logic instr_ready,
	// Execution context
	input wire logic same_block,
	input wire logic [cmpeq_pkg::REPEAT_W-1:0] repeat_count,
	// Operands
	input wire logic [15:0] bit_manip_reg,
	input wire logic [15:0] operand_data,
	output logic operand_strobe,
	output logic operand_indirect,
	output logic [6:0] operand_field,
	// Results
	output logic test_control_flag,
	output logic pc_advance,
	output logic [1:0] pc_step,
	output logic busy
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	cmpeq_pkg::decode_s dec;
	cmpeq_pkg::decode_s ctx;
	cmpeq_pkg::state_e state;
	cmpeq_pkg::state_e next_state;
	logic [15:0] const_reg;
	logic [1:0] setup_cnt;
	logic [cmpeq_pkg::REPEAT_W-1:0] iter_cnt;

	opcode_decode u_decode (
		.instr_word(instr_word),
		.dec(dec)
	);

	wire logic accept = instr_valid & instr_ready;
	wire logic [1:0] extra_long = dec.long_form ? cmpeq_pkg::EXTRA_LONG : 2'h0;
	wire logic [1:0] extra_conf = same_block ? cmpeq_pkg::EXTRA_CONFLICT : 2'h0;
	// Overhead is paid once per instruction, not per repeat iteration
	wire logic [1:0] next_setup = extra_long + extra_conf;
	wire logic last_iter = (iter_cnt == '0);
	wire logic [15:0] cmp_ref = ctx.long_form ? const_reg : bit_manip_reg;
	wire logic next_flag = (operand_data == cmp_ref);

	// Unknown opcodes are simply not taken; instr_ready stays low and the sequencer stays in ST_IDLE
	assign instr_ready = (state == cmpeq_pkg::ST_IDLE) & dec.hit;
	assign operand_strobe = (state == cmpeq_pkg::ST_COMPARE);
	assign operand_indirect = ctx.indirect;
	assign operand_field = ctx.field;
	assign pc_advance = operand_strobe & last_iter;
	assign busy = (state != cmpeq_pkg::ST_IDLE);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			cmpeq_pkg::ST_IDLE:
				if (accept)
					next_state = (next_setup == 2'h0) ? cmpeq_pkg::ST_COMPARE : cmpeq_pkg::ST_SETUP;
			cmpeq_pkg::ST_SETUP:
				if (setup_cnt == 2'h1)
					next_state = cmpeq_pkg::ST_COMPARE;
			cmpeq_pkg::ST_COMPARE:
				if (last_iter)
					next_state = cmpeq_pkg::ST_IDLE;
			default:
				next_state = cmpeq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state <= cmpeq_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ----------------------------------------
	// Context capture
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctx <= '0;
			const_reg <= cmpeq_pkg::CONST_RESET;
			pc_step <= cmpeq_pkg::WORDS_SHORT;
		end
		else if (accept)
		begin
			ctx <= dec;
			const_reg <= long_word;
			pc_step <= dec.long_form ? cmpeq_pkg::WORDS_LONG : cmpeq_pkg::WORDS_SHORT;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			setup_cnt <= 2'h0;
		else if (accept)
			setup_cnt <= next_setup;
		else if (state == cmpeq_pkg::ST_SETUP)
			setup_cnt <= setup_cnt - 2'h1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			iter_cnt <= '0;
		else if (accept)
			iter_cnt <= repeat_count;
		else if (operand_strobe & ~last_iter)
			iter_cnt <= iter_cnt - 1'h1;
	end

	// ----------------------------------------
	// Result flag
	// ----------------------------------------
	// Only the flag is written; neither operand has a write path here
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			test_control_flag <= cmpeq_pkg::FLAG_RESET;
		else if (operand_strobe)
			test_control_flag <= next_flag;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_strobe_once;
		operand_strobe && pc_advance ##1 !busy;
	endsequence

	sequence s_one_wait;
		busy && !operand_strobe ##1 s_strobe_once;
	endsequence

	AST_LONG_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
		accept && instr_word[15:8] == 8'h5F |=> ctx.long_form && const_reg == $past(long_word)
			&& operand_indirect == $past(instr_word[7]) && operand_field == $past(instr_word[6:0]))
		else $error("long form decode wrong");

	AST_SHORT_DECODE: assert property (@(posedge sys_clk) disable iff (rst)
		accept && instr_word[15:8] == 8'h5B |=> !ctx.long_form && operand_indirect == $past(instr_word[7]))
		else $error("short form decode wrong");

	AST_SHORT_CMP: assert property (@(posedge sys_clk) disable iff (rst)
		operand_strobe && !ctx.long_form |=> test_control_flag == ($past(operand_data) == $past(bit_manip_reg)))
		else $error("short compare result wrong");

	AST_LONG_CMP: assert property (@(posedge sys_clk) disable iff (rst)
		operand_strobe && ctx.long_form |=> test_control_flag == ($past(operand_data) == $past(const_reg)))
		else $error("long compare result wrong");

	AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		!operand_strobe |=> $stable(test_control_flag))
		else $error("flag changed without a compare");

	AST_PC_STEP: assert property (@(posedge sys_clk) disable iff (rst)
		pc_advance |-> pc_step == (ctx.long_form ? 2'h2 : 2'h1))
		else $error("program step does not match length");

	AST_SHORT_CONFLICT: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !dec.long_form && same_block && repeat_count == 8'h00 |=> s_one_wait)
		else $error("short form conflict timing wrong");

	AST_LONG_PLAIN: assert property (@(posedge sys_clk) disable iff (rst)
		accept && dec.long_form && !same_block && repeat_count == 8'h00 |=> s_one_wait)
		else $error("long form timing wrong");

	AST_REPEAT: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !dec.long_form && !same_block && repeat_count == 8'h02
			|=> (operand_strobe && !pc_advance) [*2] ##1 s_strobe_once)
		else $error("repeat iteration count wrong");

	sequence s_two_wait;
		busy && !operand_strobe ##1 s_one_wait;
	endsequence

	AST_SHORT_PLAIN: assert property (@(posedge sys_clk) disable iff (rst)
		accept && !dec.long_form && !same_block && repeat_count == 8'h00 |=> s_strobe_once)
		else $error("short form timing wrong");

	AST_LONG_CONFLICT: assert property (@(posedge sys_clk) disable iff (rst)
		accept && dec.long_form && same_block && repeat_count == 8'h00 |=> s_two_wait)
		else $error("long form conflict timing wrong");

	AST_REPEAT_LONG: assert property (@(posedge sys_clk) disable iff (rst)
		accept && dec.long_form && same_block && repeat_count == 8'h03
			|=> (busy && !operand_strobe) [*2] ##1 (operand_strobe && !pc_advance) [*3] ##1 s_strobe_once)
		else $error("long repeat iteration count wrong");

	AST_PC_ONCE: assert property (@(posedge sys_clk) disable iff (rst)
		pc_advance |=> !pc_advance && !operand_strobe)
		else $error("program counter advanced twice");

	AST_CTX_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		busy |=> $stable(pc_step) && $stable(operand_indirect) && $stable(operand_field))
		else $error("context changed while busy");

endmodule

`default_nettype wire

/* tb/testbench.sv */
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic instr_valid = 1'h0;
	logic [15:0] instr_word = 16'h0000;
	logic [15:0] long_word = 16'h0000;
	logic same_block = 1'h0;
	logic [cmpeq_pkg::REPEAT_W-1:0] repeat_count = 8'h00;
	logic [15:0] bit_manip_reg = 16'h0000;
	logic [15:0] operand_data = 16'h0000;
	logic instr_ready, operand_strobe, operand_indirect, test_control_flag, pc_advance, busy;
	logic [6:0] operand_field;
	logic [1:0] pc_step;
	int error_cnt = 0;
	int checks_done = 0;
	int cycle_cnt = 0;

	compare_equal_instr i_dut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
		.instr_word(instr_word), .long_word(long_word), .instr_ready(instr_ready),
		.same_block(same_block), .repeat_count(repeat_count), .bit_manip_reg(bit_manip_reg),
		.operand_data(operand_data), .operand_strobe(operand_strobe),
		.operand_indirect(operand_indirect), .operand_field(operand_field),
		.test_control_flag(test_control_flag), .pc_advance(pc_advance), .pc_step(pc_step), .busy(busy));

	always #12.5 sys_clk = ~sys_clk;

	// Whole run needs well under 200 cycles
	always @(posedge sys_clk)
	begin
		cycle_cnt++;
		if (cycle_cnt == 600)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		checks_done++;
		if (seen !== expected)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	// ----------------------------------------
	// One instruction; valid stays up until the last busy cycle, so runs busy for more than one cycle also probe refusal
	// ----------------------------------------
	task automatic run(input logic [15:0] word, input logic [15:0] imm, input logic same,
		input logic [7:0] reps, input logic [15:0] first, input logic [15:0] last, input logic flag);
		int s;
		int n;
		logic lng;
		lng = (word[15:8] == 8'h5F);
		s = lng + same;
		n = reps + 1;
		instr_word = word;
		long_word = imm;
		same_block = same;
		repeat_count = reps;
		operand_data = first;
		instr_valid = 1'h1;
		#1 check(instr_ready, 1'h1);
		@(posedge sys_clk);
		#2 check(pc_step, lng ? 2'h2 : 2'h1);
		check(operand_indirect, word[7]);
		check(operand_field, word[6:0]);
		for (int c = 1; c <= s + n; c++)
		begin
			if (c == s + n)
			begin
				operand_data = last;
				instr_valid = 1'h0;
			end
			#1 check(operand_strobe, c > s);
			check(pc_advance, c == s + n);
			check(instr_ready, 1'h0);
			@(posedge sys_clk);
			#2;
		end
		check(busy, 1'h0);
		check(test_control_flag, flag);
	endtask

	task automatic short_direct_equal();
		bit_manip_reg = 16'h0066;
		run(16'h5B60, 16'h0000, 1'h0, 8'h00, 16'h0066, 16'h0066, 1'h1);
	endtask

	task automatic short_indirect_differ();
		bit_manip_reg = 16'h00F0;
		run(16'h5B8E, 16'hFFFF, 1'h0, 8'h00, 16'h00F1, 16'h00F1, 1'h0);
	endtask

	task automatic long_ignores_bmr();
		bit_manip_reg = 16'h00CC;
		run(16'h5F60, 16'h0066, 1'h0, 8'h00, 16'h00CC, 16'h00CC, 1'h0);
		run(16'h5F7F, 16'h00CC, 1'h0, 8'h00, 16'h00CC, 16'h00CC, 1'h1);
	endtask

	task automatic conflict_cycles();
		bit_manip_reg = 16'h1234;
		run(16'h5F89, 16'h00F1, 1'h1, 8'h00, 16'h00F1, 16'h00F1, 1'h1);
		run(16'h5B05, 16'h0000, 1'h1, 8'h00, 16'h1235, 16'h1235, 1'h0);
	endtask

	task automatic repeat_last_result();
		bit_manip_reg = 16'h8001;
		run(16'h5B88, 16'h0000, 1'h0, 8'h02, 16'h0000, 16'h8001, 1'h1);
		run(16'h5FA0, 16'h8001, 1'h1, 8'h03, 16'h8001, 16'h8000, 1'h0);
	endtask

	task automatic foreign_opcodes();
		logic [15:0] words [4] = '{16'h5A80, 16'h5E00, 16'hDF00, 16'h1B00};
		foreach (words[i])
		begin
			instr_word = words[i];
			instr_valid = 1'h1;
			#1 check(instr_ready, 1'h0);
			@(posedge sys_clk);
			#2 check(busy, 1'h0);
		end
		instr_valid = 1'h0;
	endtask

	initial
	begin
		repeat (3) @(posedge sys_clk);
		#2 rst = 1'h0;
		check(test_control_flag, 1'h0);
		check(pc_step, 2'h1);
		short_direct_equal();
		short_indirect_differ();
		long_ignores_bmr();
		conflict_cycles();
		repeat_last_result();
		foreign_opcodes();
		end_of_test();
	end
endmodule

`default_nettype wire
